// ---- src/uie_regs.vh ----
// register addresses, field positions, reset values and encodings of the interrupt enable and status block
// Behaviour
// R1: extended fields writable only with enhanced enable
// R2: mask gates four sources into source register
// R3: fifo receive interrupt follows trigger level
// R4: receive source status clears with interrupt
// R5: data ready sets on push, clears empty
// R6: fifo on, mask 0-3 clear: polled mode; irq still rises on a pause event while mask 5 is set
// R7: status bit 1 flags receive overrun
// R8: bits 2-4 give head character errors
// R9: bit 5 set when holding empty
// R10: bit 6 set when fifo and shifter empty
// R11: bit 7 set on any fifo error
// R12: mask 0 enables receive data interrupt
// R13: mask 1 enables transmit ready interrupt
// R14: enabling transmit mask while empty interrupts immediately
// R15: mask 2 raises line status on bits 1-4
// R16: overrun immediate, other errors at head
// R17: mask 3 enables modem status interrupt
// R18: mask 4 sleep, enhanced enable needed
// R19: mask 5 pause interrupt, enhanced enable needed
// R20: all mask bits reset cleared
// R21: enhanced registers reached only with access key
// R22: four flow characters are plain storage
// R23: source bit 0 low while pending
`ifndef UIE_REGS_VH
`define UIE_REGS_VH
`define UIE_A_DATA 3'h0
`define UIE_A_MASK 3'h1
`define UIE_A_SRC 3'h2
`define UIE_A_LCTL 3'h3
`define UIE_A_MCTL 3'h4
`define UIE_A_LSTAT 3'h5
`define UIE_A_EFC 3'h2
`define UIE_A_RES1 3'h4
`define UIE_A_RES2 3'h5
`define UIE_A_PAU1 3'h6
`define UIE_A_PAU2 3'h7
`define UIE_KEY 8'hbf
`define UIE_EFC_EN 4
`define UIE_DLAB 7
`define UIE_MASK_RST 8'h00
`define UIE_BYTE_RST 8'h00
`define UIE_SRC_NONE 4'h1
`define UIE_SRC_LINE 4'h6
`define UIE_SRC_TOUT 4'hc
`define UIE_SRC_RXD 4'h4
`define UIE_SRC_TXR 4'h2
`define UIE_SRC_MDM 4'h0
`define UIE_SRC_PAUSE 6'h10
`endif

// ---- src/uie_status.v ----
// line status and pending-source logic
`include "uie_regs.vh"
module uie_status (
  // control
  input wire i_fifo_en,
  input wire [7:0] i_mask,
  input wire [5:0] i_rx_trig,
  input wire [5:0] i_tx_trig,
  // datapath state
  input wire [5:0] i_rx_fill,
  input wire [5:0] i_tx_fill,
  input wire i_tx_shift_empty,
  input wire [2:0] i_head_err,
  input wire i_any_err,
  input wire i_overrun,
  input wire i_modem_evt,
  input wire i_rx_timeout,
  input wire i_pause_evt,
  input wire i_tx_pend,
  // results
  output wire [7:0] o_line,
  output reg [3:0] o_code,
  output wire o_pause,
  output wire o_pending,
  output wire o_thr_empty
);
  wire rx_ready;
  wire rx_int;
  wire tx_int;
  wire line_int;
  assign rx_ready = (i_rx_fill != 6'h00); // R5
  assign o_thr_empty = (i_tx_fill == 6'h00); // R9
  // tx ready in fifo mode: below trigger
  assign tx_int = i_mask[1] & i_tx_pend; // R13 R14
  assign rx_int = i_mask[0] & (i_fifo_en ? (i_rx_fill >= i_rx_trig) : rx_ready); // R3 R4 R12
  assign o_line = {i_any_err, o_thr_empty & i_tx_shift_empty, o_thr_empty,
                   i_head_err, i_overrun, rx_ready}; // R7 R8 R9 R10 R11
  assign line_int = i_mask[2] & (|o_line[4:1]); // R15 R16
  assign o_pause = i_mask[5] & i_pause_evt; // R19
  // with mask 0-3 clear no source below is raised, so o_pending follows o_pause only
  always @* begin
    if (line_int) begin
      o_code = `UIE_SRC_LINE;
    end else if (i_mask[0] & i_rx_timeout) begin
      o_code = `UIE_SRC_TOUT;
    end else if (rx_int) begin
      o_code = `UIE_SRC_RXD;
    end else if (tx_int) begin
      o_code = `UIE_SRC_TXR;
    end else if (i_mask[3] & i_modem_evt) begin
      o_code = `UIE_SRC_MDM; // R17
    end else begin
      o_code = `UIE_SRC_NONE;
    end
  end
  assign o_pending = (o_code != `UIE_SRC_NONE) | o_pause; // R2 R6
endmodule

// ---- src/uie_top.v ----
// register bus, mask, enhanced and flow character registers of one channel
`include "uie_regs.vh"
module uie_top #(
  parameter DEPTH_W = 6
) (
  // clock and reset
  input wire i_clk,
  input wire i_nrst,
  // register bus
  input wire [2:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [7:0] o_rdata,
  // control from neighbouring blocks
  input wire [7:0] i_line_ctl,
  input wire i_fifo_en,
  input wire [5:0] i_rx_trig,
  input wire [5:0] i_tx_trig,
  // datapath state
  input wire [DEPTH_W-1:0] i_rx_fill,
  input wire [DEPTH_W-1:0] i_tx_fill,
  input wire i_tx_shift_empty,
  input wire [2:0] i_head_err,
  input wire i_any_err,
  input wire i_overrun,
  input wire i_modem_evt,
  input wire i_rx_timeout,
  input wire i_pause_evt,
  input wire i_tx_written,
  // outputs
  output reg o_irq,
  output reg o_sleep_en,
  output reg [7:0] o_mask,
  output reg [7:0] o_efc,
  output reg [7:0] o_res1,
  output reg [7:0] o_res2,
  output reg [7:0] o_pau1,
  output reg [7:0] o_pau2,
  output reg o_ext_wr_ok
);
  wire key;
  wire ext_ok;
  wire std;
  wire [7:0] line;
  wire [3:0] code;
  wire pause;
  wire pending;
  wire thr_empty;
  reg tx_pend_r;
  reg tx_pend_nxt;
  reg thr_empty_r;
  reg [7:0] mask_nxt;
  reg [7:0] rd_nxt;
  assign key = (i_line_ctl == `UIE_KEY); // R21
  assign std = ~key & ~i_line_ctl[`UIE_DLAB];
  assign ext_ok = o_efc[`UIE_EFC_EN]; // R1
  uie_status u_stat (
    .i_fifo_en(i_fifo_en),
    .i_mask(o_mask),
    .i_rx_trig(i_rx_trig),
    .i_tx_trig(i_tx_trig),
    .i_rx_fill(i_rx_fill[5:0]),
    .i_tx_fill(i_tx_fill[5:0]),
    .i_tx_shift_empty(i_tx_shift_empty),
    .i_head_err(i_head_err),
    .i_any_err(i_any_err),
    .i_overrun(i_overrun),
    .i_modem_evt(i_modem_evt),
    .i_rx_timeout(i_rx_timeout),
    .i_pause_evt(i_pause_evt),
    .i_tx_pend(tx_pend_r),
    .o_line(line),
    .o_code(code),
    .o_pause(pause),
    .o_pending(pending),
    .o_thr_empty(thr_empty)
  );
  // mask write: upper nibble kept unless enhanced functions are on
  always @* begin
    mask_nxt = o_mask;
    if (i_wr & std & (i_addr == `UIE_A_MASK)) begin
      mask_nxt[3:0] = i_wdata[3:0]; // R2
      if (ext_ok) begin
        mask_nxt[7:4] = i_wdata[7:4]; // R1 R18 R19
      end
    end
  end
  // transmit ready pending: set on emptying or fifo below trigger, or on enable while empty
  always @* begin
    tx_pend_nxt = tx_pend_r;
    if (i_fifo_en) begin
      tx_pend_nxt = (i_tx_fill[5:0] < i_tx_trig); // R13
    end else if (thr_empty & ~thr_empty_r) begin
      tx_pend_nxt = 1'b1;
    end
    if (mask_nxt[1] & ~o_mask[1] & thr_empty) begin
      tx_pend_nxt = 1'b1; // R14
    end
    // set beats clear: a new empty edge or enable wins over a source read
    if ((i_tx_written | (i_rd & std & (i_addr == `UIE_A_SRC) & (code == `UIE_SRC_TXR))) &
        ~(thr_empty & ~thr_empty_r) & ~(mask_nxt[1] & ~o_mask[1])) begin
      tx_pend_nxt = 1'b0;
    end
  end
  always @* begin
    rd_nxt = 8'h00;
    if (key) begin
      case (i_addr)
        `UIE_A_EFC: rd_nxt = o_efc;
        `UIE_A_RES1: rd_nxt = o_res1;
        `UIE_A_RES2: rd_nxt = o_res2;
        `UIE_A_PAU1: rd_nxt = o_pau1;
        `UIE_A_PAU2: rd_nxt = o_pau2;
        default: rd_nxt = 8'h00;
      endcase
    end else if (std) begin
      case (i_addr)
        `UIE_A_MASK: rd_nxt = o_mask;
        `UIE_A_SRC: rd_nxt = {{2{i_fifo_en}}, 1'b0, pause & ext_ok & (code == `UIE_SRC_NONE),
                              (pause & (code == `UIE_SRC_NONE)) ? 4'h0 : code}; // R23
        `UIE_A_LSTAT: rd_nxt = line;
        default: rd_nxt = 8'h00;
      endcase
    end
  end
  always @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_mask <= `UIE_MASK_RST; // R20
      o_efc <= `UIE_BYTE_RST;
      o_res1 <= `UIE_BYTE_RST;
      o_res2 <= `UIE_BYTE_RST;
      o_pau1 <= `UIE_BYTE_RST;
      o_pau2 <= `UIE_BYTE_RST;
      o_rdata <= 8'h00;
      o_irq <= 1'b0;
      o_sleep_en <= 1'b0;
      o_ext_wr_ok <= 1'b0;
      tx_pend_r <= 1'b0;
      thr_empty_r <= 1'b1;
    end else begin
      o_mask <= mask_nxt;
      o_sleep_en <= mask_nxt[4]; // R18
      o_rdata <= rd_nxt;
      o_irq <= pending;
      o_ext_wr_ok <= ext_ok;
      tx_pend_r <= tx_pend_nxt;
      thr_empty_r <= thr_empty;
      if (i_wr & key) begin
        case (i_addr)
          `UIE_A_EFC: o_efc <= i_wdata; // R21
          `UIE_A_RES1: o_res1 <= i_wdata; // R22
          `UIE_A_RES2: o_res2 <= i_wdata;
          `UIE_A_PAU1: o_pau1 <= i_wdata;
          `UIE_A_PAU2: o_pau2 <= i_wdata;
          default: o_efc <= o_efc;
        endcase
      end
    end
  end
endmodule

// ---- dv/uie_assertions.sv ----
// port assertions of the interrupt enable and status block
module uie_chk #(parameter DEPTH_W = 6) (
  input wire i_clk,
  input wire i_nrst,
  input wire [2:0] i_addr,
  input wire [7:0] i_wdata,
  input wire i_wr,
  input wire [7:0] i_line_ctl,
  input wire i_fifo_en,
  input wire [5:0] i_rx_trig,
  input wire [DEPTH_W-1:0] i_rx_fill,
  input wire [DEPTH_W-1:0] i_tx_fill,
  input wire i_tx_shift_empty,
  input wire [2:0] i_head_err,
  input wire i_any_err,
  input wire i_overrun,
  input wire i_rx_timeout,
  input wire [7:0] o_rdata,
  input wire o_irq,
  input wire [7:0] o_mask,
  input wire [7:0] o_efc,
  input wire [7:0] o_res1
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [7:0] wd_q;
  reg [7:0] ls_q;
  reg hit_q;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  // expected values one cycle on, matching the registered read path
  always @(posedge i_clk) begin
    wd_q <= i_wdata;
    hit_q <= i_rx_fill >= i_rx_trig;
    ls_q <= {i_any_err, i_tx_fill == 0 && i_tx_shift_empty, i_tx_fill == 0, i_head_err, i_overrun, i_rx_fill != 0};
  end
  mask_reset_a: assert property (!$past(i_nrst) |-> o_mask == 8'h00)
    else $error("mask not clear");
  ext_gate_a: assert property (i_wr && i_addr == 3'h1 && !i_line_ctl[7] && !o_efc[4] |=> $stable(o_mask[7:4]))
    else $error("upper mask written");
  mask_write_a: assert property (i_wr && i_addr == 3'h1 && !i_line_ctl[7] |=> o_mask[3:0] == wd_q[3:0])
    else $error("mask write lost");
  key_write_a: assert property (i_wr && i_line_ctl == 8'hbf && i_addr == 3'h4 |=> o_res1 == wd_q)
    else $error("character write lost");
  line_read_a: assert property (i_addr == 3'h5 && !i_line_ctl[7] |=> o_rdata == ls_q)
    else $error("line status wrong");
  polled_a: assert property (o_mask == 8'h00 [*2] |-> !o_irq)
    else $error("irq while polled");
  rx_level_a: assert property (o_mask == 8'h01 && i_fifo_en && !i_rx_timeout |=> o_irq == hit_q)
    else $error("rx irq level wrong");
  overrun_irq_a: assert property (o_mask == 8'h04 && i_overrun |=> o_irq)
    else $error("overrun irq late");
endmodule
bind uie_top uie_chk #(.DEPTH_W(DEPTH_W)) i_uie_chk (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_line_ctl(i_line_ctl), .i_fifo_en(i_fifo_en), .i_rx_trig(i_rx_trig),
  .i_rx_fill(i_rx_fill), .i_tx_fill(i_tx_fill), .i_tx_shift_empty(i_tx_shift_empty), .i_head_err(i_head_err),
  .i_any_err(i_any_err), .i_overrun(i_overrun), .i_rx_timeout(i_rx_timeout), .o_rdata(o_rdata),
  .o_irq(o_irq), .o_mask(o_mask), .o_efc(o_efc), .o_res1(o_res1));

// ---- dv/uie_host.sv ----
// host processor model on the register bus
module uie_host (
  input wire i_clk,
  input wire [7:0] i_rdata,
  output logic [2:0] o_addr,
  output logic [7:0] o_wdata,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_line_ctl
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_addr = 3'h0;
    o_wdata = 8'h00;
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_line_ctl = 8'h00;
  end
  // data is inverted after a write so a stale byte is never mistaken for a new one
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_wdata = d;
    o_wr = 1'b1;
    @(negedge i_clk);
    o_wr = 1'b0;
    o_wdata = ~d;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_addr = a;
    o_rd = 1'b1;
    @(negedge i_clk);
    o_rd = 1'b0;
    d = i_rdata;
  endtask
  task automatic key(input logic [7:0] v);
    @(negedge i_clk);
    o_line_ctl = v;
  endtask
endmodule

// ---- dv/tb.sv ----
// top testbench of the interrupt enable and status block
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk = 0, i_nrst = 0, fe = 0, se = 1, ae = 0, ov = 0, me = 0, wr, rd, irq, slp;
  logic tmo = 0, pe = 0, tw = 0, ewo;
  logic [5:0] rf = 0, tf = 0, tt = 6'h01;
  logic [2:0] he = 0, a;
  logic [7:0] wd, rdat, ld, v, om, oe, r1, r2, p1, p2;
  int n_mismatch = 0, samples_checked = 0;
  always #10 i_clk = ~i_clk;
  uie_host i_uie_host (.i_clk(i_clk), .i_rdata(rdat), .o_addr(a), .o_wdata(wd), .o_wr(wr), .o_rd(rd),
    .o_line_ctl(ld));
  uie_top i_uie_top (.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(a), .i_wdata(wd), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdat), .i_line_ctl(ld), .i_fifo_en(fe), .i_rx_trig(6'h04), .i_tx_trig(tt), .i_rx_fill(rf),
    .i_tx_fill(tf), .i_tx_shift_empty(se), .i_head_err(he), .i_any_err(ae), .i_overrun(ov),
    .i_modem_evt(me), .i_rx_timeout(tmo), .i_pause_evt(pe), .i_tx_written(tw), .o_irq(irq),
    .o_sleep_en(slp), .o_mask(om), .o_efc(oe), .o_res1(r1), .o_res2(r2), .o_pau1(p1), .o_pau2(p2),
    .o_ext_wr_ok(ewo));
  task conclude;
    if (n_mismatch == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk_rd(input logic [2:0] ad, input logic [7:0] e);
    i_uie_host.rd(ad, v);
    `CHK("rdata", e, v)
  endtask
  // irq is two registers behind a mask write, so three cycles always suffice
  task s;
    repeat (3) @(negedge i_clk);
  endtask
  initial begin
    repeat (6) @(negedge i_clk);
    i_nrst = 1;
    chk_rd(3'h1, 8'h00);
    chk_rd(3'h5, 8'h60);
    i_uie_host.wr(3'h1, 8'hff);
    chk_rd(3'h1, 8'h0f);
    `CHK("ext_ok", 1'b0, ewo)
    i_uie_host.key(8'hbf);
    i_uie_host.wr(3'h2, 8'h10);
    for (int k = 4; k < 8; k++) i_uie_host.wr(k[2:0], 8'ha0 + k[7:0]);
    for (int k = 4; k < 8; k++) chk_rd(k[2:0], 8'ha0 + k[7:0]);
    `CHK("efc", 8'h10, oe)
    `CHK("res1", 8'ha4, r1)
    `CHK("res2", 8'ha5, r2)
    `CHK("pau1", 8'ha6, p1)
    `CHK("pau2", 8'ha7, p2)
    `CHK("ext_ok", 1'b1, ewo)
    i_uie_host.key(8'h00);
    i_uie_host.wr(3'h4, 8'h55);
    i_uie_host.key(8'hbf);
    chk_rd(3'h4, 8'ha4);
    i_uie_host.key(8'h00);
    i_uie_host.wr(3'h1, 8'h31);
    chk_rd(3'h1, 8'h31);
    `CHK("mask", 8'h31, om)
    `CHK("sleep", 1'b1, slp)
    i_uie_host.wr(3'h1, 8'h01);
    fe = 1;
    rf = 3;
    s;
    `CHK("irq", 1'b0, irq)
    rf = 4;
    s;
    `CHK("irq", 1'b1, irq)
    chk_rd(3'h2, 8'hc4);
    rf = 3;
    s;
    `CHK("irq", 1'b0, irq)
    chk_rd(3'h2, 8'hc1);
    i_uie_host.wr(3'h1, 8'h00);
    {rf, tf, se, he, ae, ov} = {6'h08, 6'h02, 1'b0, 3'h5, 1'b1, 1'b1};
    s;
    `CHK("irq", 1'b0, irq)
    chk_rd(3'h5, 8'h97);
    i_uie_host.wr(3'h1, 8'h04);
    s;
    `CHK("irq", 1'b1, irq)
    chk_rd(3'h2, 8'hc6);
    {ov, he, me, fe, tf} = {1'b0, 3'h0, 1'b1, 1'b0, 6'h00};
    i_uie_host.wr(3'h1, 8'h08);
    s;
    `CHK("irq", 1'b1, irq)
    me = 0;
    i_uie_host.wr(3'h1, 8'h02);
    s;
    `CHK("irq", 1'b1, irq)
    chk_rd(3'h2, 8'h02);
    s;
    `CHK("irq", 1'b0, irq)
    // pending was just cleared, so only the enable edge can raise it again
    i_uie_host.wr(3'h1, 8'h00);
    i_uie_host.wr(3'h1, 8'h02);
    s;
    `CHK("irq", 1'b1, irq)
    tw = 1;
    @(negedge i_clk);
    tw = 0;
    s;
    `CHK("irq", 1'b0, irq)
    tmo = 1;
    i_uie_host.wr(3'h1, 8'h01);
    chk_rd(3'h2, 8'h0c);
    tmo = 0;
    chk_rd(3'h2, 8'h04);
    pe = 1;
    i_uie_host.wr(3'h1, 8'h20);
    s;
    `CHK("irq", 1'b1, irq)
    chk_rd(3'h2, 8'h10);
    pe = 0;
    {fe, tf, tt} = {1'b1, 6'h04, 6'h08};
    i_uie_host.wr(3'h1, 8'h02);
    s;
    `CHK("irq", 1'b1, irq)
    tf = 6'h08;
    s;
    `CHK("irq", 1'b0, irq)
    conclude;
  end
endmodule
